// ==== src/aircfg_pkg.sv ====
// Purpose: Shared constants and types for the analog input range configuration block
// Assumes: Converter samples arrive as sign plus 13-bit magnitude, full scale 4095 codes
// Notes: Configuration fields follow the bit weights of the range configuration byte
package aircfg_pkg;

  // ----------------------------------------------------------------
  // Configuration byte
  // ----------------------------------------------------------------
  localparam int CHANNELS = 4;
  localparam int SLOTS = 18;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_RANGE10_LSB = 0;
  localparam int CFG_UNIPOLAR_BIT = 4;
  localparam int CFG_LIVE_ZERO_BIT = 5;
  localparam int CFG_OVR_MON_BIT = 6;
  localparam int CFG_RSVD_BIT = 7;
  localparam logic [7:0] CFG_WRITABLE_MASK = 8'h7F;

  // ----------------------------------------------------------------
  // Converter scale
  // ----------------------------------------------------------------
  localparam int MAG_W = 13;
  localparam int CODE_W = 12;
  localparam logic [12:0] FULL_SCALE_CODE = 13'h0FFF;
  localparam int FULL_SCALE_UA = 20000;
  localparam int OPEN_LIMIT_UA = 2080;
  localparam logic [12:0] OPEN_LIMIT_CODE =
    13'((OPEN_LIMIT_UA * 4096 + FULL_SCALE_UA - 1) / FULL_SCALE_UA);
  localparam logic [12:0] OVR_TOL_CODE = 13'h0000;

  typedef enum logic [1:0] {
    AIRC_RNG_1V,
    AIRC_RNG_10V,
    AIRC_RNG_LZ_1V,
    AIRC_RNG_LZ_10V
  } aircfg_range_t;

  typedef struct packed {
    logic rsvd;
    logic ovr_mon;
    logic live_zero;
    logic unipolar;
    logic [3:0] range10;
  } aircfg_cfg_t;

  typedef struct packed {
    logic open_circ;
    logic overrange;
    logic [11:0] code;
  } aircfg_res_t;

endpackage

// ==== src/aircfg_res_mem.sv ====
// Purpose: Small result store, one word per input channel
// Assumes: Single write port and single registered read port
// Notes: A read of the word being written returns the old contents
`timescale 1ns/100ps
module aircfg_res_mem #(
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire aircfg_pkg::aircfg_res_t wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output aircfg_pkg::aircfg_res_t rd_data_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  aircfg_pkg::aircfg_res_t mem_reg [DEPTH];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      rd_data_o <= '0;
    end else begin
      if (wr_en_i) begin
        mem_reg[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end

endmodule

// ==== src/aircfg_top.sv ====
// Purpose: Range configuration, result coding and monitoring for a four-input analog module
// Assumes: All inputs synchronous to CORE_CLK_I; front end converts and reports raw samples
// Notes: Configuration byte is written over the documented output operand port
`timescale 1ns/100ps

// Contract
// - A zero configuration byte gives four bipolar 1 V / 20 mA inputs with no monitoring.
// - Each weight of the configuration byte is decoded as an independent bit.
// - Bits 0 to 3 each put inputs one to four in the 10 V range, clear means 1 V / 20 mA.
// - Bit 4 gives unipolar 12-bit unsigned results, usable with open-circuit monitoring.
// - Bit 5 puts all inputs in live-zero range and flags open circuit below 2.08 mA.
// - Value 47 puts all four inputs in the 2 to 10 V live-zero range.
// - Bit 6 monitors all inputs for values above nominal plus tolerance and flags overrange.
// - Bipolar results are 11 magnitude bits plus a sign bit.
// - Ranges come only from the configuration byte; current or voltage follows wiring.
// - Ready is high while processor operation is fault free and drops on a fault.
// - One failure marker per slot 1 to 18 is set when that slot drops out.
module aircfg_top #(
  parameter logic [12:0] OVR_TOL = aircfg_pkg::OVR_TOL_CODE
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CFG_WR_I,
  input wire logic [7:0] CFG_DATA_I,
  output logic [7:0] CFG_O,
  input wire logic SMP_VALID_I,
  input wire logic [1:0] SMP_CH_I,
  input wire logic SMP_NEG_I,
  input wire logic [12:0] SMP_MAG_I,
  input wire logic [1:0] RES_ADDR_I,
  output aircfg_pkg::aircfg_res_t RES_DATA_O,
  output logic RES_UPD_O,
  output logic [7:0] CH_RANGE_O,
  output logic UNIPOLAR_O,
  output logic [3:0] OPEN_FLAG_O,
  output logic [3:0] OVR_FLAG_O,
  input wire logic PROC_FAULT_I,
  output logic READY_O,
  input wire logic [17:0] SLOT_DROP_I,
  input wire logic [17:0] SLOT_CLR_I,
  output logic [17:0] SLOT_DROP_FAIL_O
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic aircfg_pkg::aircfg_range_t range_of(
    input aircfg_pkg::aircfg_cfg_t cfg,
    input logic [1:0] ch
  );
    logic r10;
    r10 = cfg.range10[ch];
    if (cfg.live_zero) begin
      range_of = r10 ? aircfg_pkg::AIRC_RNG_LZ_10V : aircfg_pkg::AIRC_RNG_LZ_1V;
    end else begin
      range_of = r10 ? aircfg_pkg::AIRC_RNG_10V : aircfg_pkg::AIRC_RNG_1V;
    end
  endfunction

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  aircfg_pkg::aircfg_cfg_t cfg_reg;
  aircfg_pkg::aircfg_cfg_t cfg_next;
  wire logic [7:0] cfg_wr_masked;

  assign cfg_wr_masked = CFG_DATA_I & aircfg_pkg::CFG_WRITABLE_MASK;
  assign cfg_next = CFG_WR_I ? aircfg_pkg::aircfg_cfg_t'(cfg_wr_masked) : cfg_reg;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg_reg <= aircfg_pkg::aircfg_cfg_t'(aircfg_pkg::CFG_RESET);
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel range outputs
  // ----------------------------------------------------------------
  logic [7:0] range_reg;
  wire logic [7:0] range_next;

  genvar gi;
  generate
    for (gi = 0; gi < aircfg_pkg::CHANNELS; gi++) begin : g_rng
      assign range_next[2*gi+1:2*gi] = range_of(cfg_next, 2'(gi));
    end
  endgenerate

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      range_reg <= '0;
      UNIPOLAR_O <= 1'b0;
    end else begin
      range_reg <= range_next;
      UNIPOLAR_O <= cfg_next.unipolar;
    end
  end

  assign CFG_O = cfg_reg;
  assign CH_RANGE_O = range_reg;

  // ----------------------------------------------------------------
  // Result coding, using the byte that stands when the sample arrives
  // ----------------------------------------------------------------
  wire logic mag_over_fs;
  wire logic [11:0] mag_sat;
  wire logic [11:0] code_bip;
  wire logic [11:0] code_uni;
  wire logic is_open;
  wire logic is_ovr;
  aircfg_pkg::aircfg_res_t res_word;

  assign mag_over_fs = SMP_MAG_I > aircfg_pkg::FULL_SCALE_CODE;
  assign mag_sat = mag_over_fs ? 12'hFFF : SMP_MAG_I[11:0];
  assign code_bip = {SMP_NEG_I, mag_sat[11:1]};
  assign code_uni = SMP_NEG_I ? 12'h000 : mag_sat;
  assign is_open = cfg_reg.live_zero &&
    (SMP_NEG_I || (SMP_MAG_I < aircfg_pkg::OPEN_LIMIT_CODE));
  assign is_ovr = cfg_reg.ovr_mon && !SMP_NEG_I &&
    (SMP_MAG_I > (aircfg_pkg::FULL_SCALE_CODE + OVR_TOL));
  assign res_word.open_circ = is_open;
  assign res_word.overrange = is_ovr;
  assign res_word.code = cfg_reg.unipolar ? code_uni : code_bip;

  aircfg_res_mem #(
    .DEPTH(aircfg_pkg::CHANNELS),
    .AW(2)
  ) u_mem (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .wr_en_i(SMP_VALID_I),
    .wr_addr_i(SMP_CH_I),
    .wr_data_i(res_word),
    .rd_addr_i(RES_ADDR_I),
    .rd_data_o(RES_DATA_O)
  );

  // ----------------------------------------------------------------
  // Channel flags and update pulse
  // ----------------------------------------------------------------
  logic [3:0] open_reg;
  logic [3:0] ovr_reg;
  logic upd_reg;
  wire logic [3:0] ch_hit;
  wire logic [3:0] open_next;
  wire logic [3:0] ovr_next;

  generate
    for (gi = 0; gi < aircfg_pkg::CHANNELS; gi++) begin : g_flag
      assign ch_hit[gi] = SMP_VALID_I && (SMP_CH_I == 2'(gi));
      assign open_next[gi] = ch_hit[gi] ? is_open : open_reg[gi];
      assign ovr_next[gi] = ch_hit[gi] ? is_ovr : ovr_reg[gi];
    end
  endgenerate

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      open_reg <= '0;
      ovr_reg <= '0;
      upd_reg <= 1'b0;
    end else begin
      open_reg <= open_next;
      ovr_reg <= ovr_next;
      upd_reg <= SMP_VALID_I;
    end
  end

  assign OPEN_FLAG_O = open_reg;
  assign OVR_FLAG_O = ovr_reg;
  assign RES_UPD_O = upd_reg;

  // ----------------------------------------------------------------
  // Ready indication and slot failure markers
  // ----------------------------------------------------------------
  logic ready_reg;
  logic [17:0] drop_reg;
  wire logic [17:0] drop_next;

  assign drop_next = (drop_reg & ~SLOT_CLR_I) | SLOT_DROP_I;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ready_reg <= 1'b0;
      drop_reg <= '0;
    end else begin
      ready_reg <= !PROC_FAULT_I;
      drop_reg <= drop_next;
    end
  end

  assign READY_O = ready_reg;
  assign SLOT_DROP_FAIL_O = drop_reg;

  // ----------------------------------------------------------------
  // Assertions: configuration
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);

  zero_cfg_a: assert property ((CFG_O == 8'h00) |->
    (CH_RANGE_O == 8'h00) && !UNIPOLAR_O)
    else $error("zero byte not bipolar 1 V");

  bit_decode_a: assert property (CFG_WR_I |=>
    (CFG_O[6:0] == $past(CFG_DATA_I[6:0])))
    else $error("config bits not stored independently");

  rsvd_ignored_a: assert property (
    CFG_O[aircfg_pkg::CFG_RSVD_BIT] == 1'b0)
    else $error("reserved bit stored");

  range10_a: assert property (CFG_WR_I && !CFG_DATA_I[5] |=>
    (CH_RANGE_O[0] == $past(CFG_DATA_I[0])) && (CH_RANGE_O[2] == $past(CFG_DATA_I[1])) &&
    (CH_RANGE_O[4] == $past(CFG_DATA_I[2])) && (CH_RANGE_O[6] == $past(CFG_DATA_I[3])))
    else $error("10 V range select wrong");

  lz47_a: assert property (CFG_WR_I && (CFG_DATA_I == 8'h2F) |=>
    (CH_RANGE_O == 8'hFF))
    else $error("value 47 not 2-10 V on all inputs");

  lz_all_a: assert property (CFG_O[aircfg_pkg::CFG_LIVE_ZERO_BIT] |->
    CH_RANGE_O[7] && CH_RANGE_O[5] && CH_RANGE_O[3] && CH_RANGE_O[1])
    else $error("live zero not on all inputs");

  lz_off_a: assert property (!CFG_O[aircfg_pkg::CFG_LIVE_ZERO_BIT] |->
    !CH_RANGE_O[7] && !CH_RANGE_O[5] && !CH_RANGE_O[3] && !CH_RANGE_O[1])
    else $error("live zero set with bit clear");

  uni_out_a: assert property (
    UNIPOLAR_O == CFG_O[aircfg_pkg::CFG_UNIPOLAR_BIT])
    else $error("unipolar flag differs from byte");

  range_src_a: assert property (!CFG_WR_I |=> $stable(CH_RANGE_O))
    else $error("range changed without write");

  cfg_hold_a: assert property (!CFG_WR_I |=> $stable(CFG_O))
    else $error("byte changed without write");

  // ----------------------------------------------------------------
  // Assertions: results
  // ----------------------------------------------------------------
  uni_code_a: assert property (SMP_VALID_I && cfg_reg.unipolar && SMP_NEG_I &&
    (RES_ADDR_I == SMP_CH_I) ##1 (RES_ADDR_I == $past(SMP_CH_I)) |=>
    (RES_DATA_O.code == 12'h000))
    else $error("unipolar negative not zero");

  bip_code_a: assert property (SMP_VALID_I && !cfg_reg.unipolar &&
    (RES_ADDR_I == SMP_CH_I) ##1 (RES_ADDR_I == $past(SMP_CH_I)) |=>
    (RES_DATA_O.code[11] == $past(SMP_NEG_I, 2)))
    else $error("bipolar sign bit wrong");

  open_flag_a: assert property (SMP_VALID_I && cfg_reg.live_zero && !SMP_NEG_I &&
    (SMP_MAG_I < 13'h01AA) |=> OPEN_FLAG_O[$past(SMP_CH_I)])
    else $error("open circuit not flagged");

  ovr_flag_a: assert property (SMP_VALID_I && SMP_MAG_I[12] && !SMP_NEG_I &&
    cfg_reg.ovr_mon && (OVR_TOL == 13'h0000) |=> OVR_FLAG_O[$past(SMP_CH_I)])
    else $error("overrange not flagged");

  no_mon_a: assert property (SMP_VALID_I && (CFG_O[6:5] == 2'b00) |=>
    !OPEN_FLAG_O[$past(SMP_CH_I)] && !OVR_FLAG_O[$past(SMP_CH_I)])
    else $error("monitoring active with bits clear");

  flag_hold_a: assert property (!SMP_VALID_I |=>
    $stable(OPEN_FLAG_O) && $stable(OVR_FLAG_O))
    else $error("flags moved without a sample");

  new_cfg_a: assert property (CFG_WR_I ##1 SMP_VALID_I |->
    (res_word.open_circ == ($past(CFG_DATA_I[5]) && (SMP_NEG_I || (SMP_MAG_I < 13'h01AA)))) &&
    (res_word.overrange == ($past(CFG_DATA_I[6]) && !SMP_NEG_I &&
    (SMP_MAG_I > aircfg_pkg::FULL_SCALE_CODE + OVR_TOL))))
    else $error("new byte not applied to next conversion");

  upd_pulse_a: assert property (1'b1 |=> (RES_UPD_O == $past(SMP_VALID_I)))
    else $error("update pulse misplaced");

  // ----------------------------------------------------------------
  // Assertions: ready and slot markers
  // ----------------------------------------------------------------
  ready_a: assert property (PROC_FAULT_I |=> !READY_O)
    else $error("ready stayed high on fault");

  ready_up_a: assert property (!PROC_FAULT_I |=> READY_O)
    else $error("ready low without fault");

  drop_set_a: assert property ((SLOT_DROP_I & SLOT_CLR_I) != 18'h00000 |=>
    ((SLOT_DROP_FAIL_O & $past(SLOT_DROP_I)) == $past(SLOT_DROP_I)))
    else $error("slot drop lost to clear");

  mark_keep_a: assert property (SLOT_CLR_I == 18'h00000 |=>
    ((SLOT_DROP_FAIL_O & $past(SLOT_DROP_FAIL_O)) == $past(SLOT_DROP_FAIL_O)))
    else $error("slot marker lost without clear");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  lz_cov_c: cover property (CFG_WR_I && (CFG_DATA_I == 8'h30));
  open_cov_c: cover property (SMP_VALID_I && is_open);
  ovr_cov_c: cover property (SMP_VALID_I && is_ovr);
  drop_cov_c: cover property (SLOT_DROP_I != 18'h00000);
  uni_cov_c: cover property (SMP_VALID_I && cfg_reg.unipolar && SMP_NEG_I);

endmodule

// ==== verification/aircfg_host_model.sv ====
// Purpose: Host controller model that writes the range configuration byte
// Assumes: A write starts just after a falling edge and lasts one clock cycle
// Notes: Idle data lines show the inverse of the last byte
`timescale 1ns/100ps
module aircfg_host_model (
  input wire logic clk_i,
  output logic wr_o,
  output logic [7:0] data_o
);
  // ----------------------------------------------------------------
  // Configuration writes
  // ----------------------------------------------------------------
  initial begin
    wr_o = 1'b0;
    data_o = 8'h00;
  end

  // Top bit is written as zero unless a scenario asks to break that
  task automatic write_cfg(input logic [7:0] v, input logic keep_top);
    @(negedge clk_i);
    wr_o = 1'b1;
    data_o = keep_top ? v : {1'b0, v[6:0]};
    @(negedge clk_i);
    wr_o = 1'b0;
    data_o = ~data_o;
  endtask
endmodule

// ==== verification/analog_input_range_config_bench.sv ====
// Purpose: Self-checking bench for the analog input range configuration block
// Assumes: Inputs change at the falling edge, default overrange tolerance
// Notes: Configuration writes come from the host model
`timescale 1ns/100ps
module analog_input_range_config_bench;
  logic clk, rst, wr, smp_valid, smp_neg, fault, upd, unip, ready;
  logic [7:0] wdata, cfg_o, ch_range, cur;
  logic [1:0] smp_ch, res_addr;
  logic [12:0] smp_mag;
  logic [3:0] open_f, ovr_f;
  logic [17:0] drop, clr, markers;
  aircfg_pkg::aircfg_res_t res;
  int err_count = 0;
  int n_checks = 0;
  logic [7:0] tbl [12] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0F, 8'h10, 8'h1F, 8'h20, 8'h2F,
    8'h30, 8'h3F, 8'h40};

  aircfg_top i_aircfg_top (.CORE_CLK_I(clk), .RST_I(rst), .CFG_WR_I(wr), .CFG_DATA_I(wdata),
    .CFG_O(cfg_o), .SMP_VALID_I(smp_valid), .SMP_CH_I(smp_ch), .SMP_NEG_I(smp_neg),
    .SMP_MAG_I(smp_mag), .RES_ADDR_I(res_addr), .RES_DATA_O(res), .RES_UPD_O(upd),
    .CH_RANGE_O(ch_range), .UNIPOLAR_O(unip), .OPEN_FLAG_O(open_f), .OVR_FLAG_O(ovr_f),
    .PROC_FAULT_I(fault), .READY_O(ready), .SLOT_DROP_I(drop), .SLOT_CLR_I(clr),
    .SLOT_DROP_FAIL_O(markers));
  aircfg_host_model i_aircfg_host_model (.clk_i(clk), .wr_o(wr), .data_o(wdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [13:0] exp_res(input logic [7:0] c, input logic neg,
    input logic [12:0] mag);
    logic [11:0] sat;
    logic [11:0] code;
    sat = (mag > 13'h0FFF) ? 12'hFFF : mag[11:0];
    code = c[4] ? (neg ? 12'h000 : sat) : {neg, sat[11:1]};
    return {c[5] && (neg || mag < 13'h01AA), c[6] && !neg && mag > 13'h0FFF, code};
  endfunction

  task automatic set_cfg(input logic [7:0] v, input logic keep_top);
    i_aircfg_host_model.write_cfg(v, keep_top);
    cur = v & 8'h7F;
    chk({10'h000, cfg_o}, {10'h000, cur}, "config");
    for (int i = 0; i < 4; i++) begin
      chk({16'h0000, ch_range[2*i +: 2]}, {16'h0000, cur[5], cur[i]}, "range");
    end
    chk({17'h00000, unip}, {17'h00000, cur[4]}, "unipolar");
  endtask

  task automatic sample(input logic [1:0] ch, input logic neg, input logic [12:0] mag);
    logic [13:0] e;
    e = exp_res(cur, neg, mag);
    @(negedge clk);
    smp_valid = 1'b1;
    smp_ch = ch;
    smp_neg = neg;
    smp_mag = mag;
    res_addr = ch;
    @(negedge clk);
    smp_valid = 1'b0;
    smp_mag = ~mag;
    chk({17'h00000, upd}, 18'h00001, "update");
    chk({17'h00000, open_f[ch]}, {17'h00000, e[13]}, "open flag");
    chk({17'h00000, ovr_f[ch]}, {17'h00000, e[12]}, "overrange flag");
    @(negedge clk);
    chk({4'h0, res}, {4'h0, e}, "result");
    chk({17'h00000, upd}, 18'h00000, "update pulse");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({10'h000, cfg_o}, 18'h00000, "reset config");
    chk({10'h000, ch_range}, 18'h00000, "reset ranges");
    chk({17'h00000, ready}, 18'h00001, "ready");
    chk(markers, 18'h00000, "reset markers");
    cur = 8'h00;
  endtask

  task automatic t_table;
    foreach (tbl[k]) begin
      set_cfg(tbl[k], 1'b0);
    end
    set_cfg(8'hC5, 1'b1);
  endtask

  task automatic t_samples;
    set_cfg(8'h00, 1'b0);
    sample(2'h0, 1'b1, 13'h0155);
    sample(2'h3, 1'b0, 13'h1000);
    set_cfg(8'h10, 1'b0);
    sample(2'h1, 1'b1, 13'h0064);
    sample(2'h2, 1'b0, 13'h1234);
    set_cfg(8'h30, 1'b0);
    sample(2'h0, 1'b0, 13'h01A9);
    sample(2'h0, 1'b0, 13'h01AA);
    set_cfg(8'h20, 1'b0);
    sample(2'h2, 1'b1, 13'h0800);
    set_cfg(8'h40, 1'b0);
    sample(2'h3, 1'b0, 13'h1000);
    sample(2'h3, 1'b0, 13'h0FFF);
    sample(2'h1, 1'b1, 13'h1FFF);
    set_cfg(8'h00, 1'b0);
    sample(2'h3, 1'b0, 13'h1000);
    // Sample taken at the edge right after the write edge
    cur = 8'h40;
    fork
      i_aircfg_host_model.write_cfg(8'h40, 1'b0);
      begin
        @(negedge clk);
        sample(2'h3, 1'b0, 13'h1000);
      end
    join
    chk({10'h000, cfg_o}, {10'h000, cur}, "config");
  endtask

  task automatic t_ready_slots;
    fault = 1'b1;
    @(negedge clk);
    chk({17'h00000, ready}, 18'h00000, "fault");
    fault = 1'b0;
    drop = 18'h20001;
    @(negedge clk);
    chk({17'h00000, ready}, 18'h00001, "recover");
    drop = 18'h00000;
    @(negedge clk);
    chk(markers, 18'h20001, "sticky");
    clr = 18'h3FFFF;
    drop = 18'h20000;
    @(negedge clk);
    chk(markers, 18'h20000, "set wins");
    clr = 18'h00000;
    drop = 18'h00000;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    {smp_valid, smp_neg, fault} = 3'h0;
    {smp_ch, res_addr} = 4'h0;
    smp_mag = 13'h0000;
    {drop, clr} = 36'h000000000;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_table();
    t_samples();
    t_ready_slots();
    report_and_stop();
  end
endmodule
